/* File: hdl/wdoc_defines.vh */
// Register map, field positions, codes and reset values of the watchdog
`ifndef WDOC_DEFINES_VH
`define WDOC_DEFINES_VH
`define WDOC_OFF_MODE 12'h000
`define WDOC_OFF_CMD 12'h004
`define WDOC_OFF_NMIFLG 12'h008
`define WDOC_OFF_IRQ_STAT 12'h00C
`define WDOC_OFF_IRQ_MASK 12'h010
`define WDOC_OFF_CNT 12'h014
`define WDOC_BIT_EN 7
`define WDOC_BIT_PER_HI 6
`define WDOC_BIT_PER_LO 4
`define WDOC_BIT_IDLE 2
`define WDOC_BIT_RSEL 1
`define WDOC_MODE_RST 8'h82
`define WDOC_CODE_CLEAR 8'h4E
`define WDOC_CODE_DISABLE 8'hB1
`define WDOC_RST_STATES 6'h20
`define WDOC_CNT_W 25
`define WDOC_EXP_P0 5'h0F
`define WDOC_EXP_P1 5'h11
`define WDOC_EXP_P2 5'h13
`define WDOC_EXP_P3 5'h15
`define WDOC_EXP_P4 5'h17
`define WDOC_EXP_P5 5'h19
`endif

/* File: hdl/wdoc_top.v */
// Watchdog timer with overflow interrupt or chip reset, APB register slave
`timescale 1ns/100ps
// Function
// - Overflow with reset-select 0 raises NMI
// - Interrupt sets watchdog flag in NMI flags
// - Timeout low with interrupt, high on clear
// - Overflow with reset-select 1: 32-cycle reset
// - Watchdog reset forces undivided oscillator clocking
// - Period select resets to 000
// - Enable bit resets to 1
// - Clear enable then code B1 disables
// - Writing enable 1 alone re-enables
// - Reset-select resets to 1
// - Clear code 4E zeroes and restarts counter
// - Period 011 overflows after 2^21 clocks
// - Periods 2^15..2^25; codes 110/111 prohibited
// - In idle, count only if idle bit set
// - Counter halts during debug mode
// - Binary counter driven by system clock
`include "wdoc_defines.vh"
module wdoc_top #(
  parameter CNT_W = `WDOC_CNT_W
) (
  input wire SYS_CLK,
  input wire SYS_RST,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  input wire IDLE_MODE,
  input wire DEBUG_HALT,
  output reg WATCHDOG_INTERRUPT,
  output reg TIMEOUT_OUTPUT_N,
  output reg CHIP_RESET,
  output reg CLOCK_GEAR_INIT,
  output reg IRQ
);
  localparam [1:0] ST_RUN = 2'h0;
  localparam [1:0] ST_OFF = 2'h1;
  localparam [1:0] ST_RST = 2'h2;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [7:0] mode_q;
  reg [7:0] mode_d;
  reg [CNT_W-1:0] cnt_q;
  reg [CNT_W-1:0] cnt_d;
  reg nmi_flag_q;
  reg nmi_flag_d;
  reg [1:0] stat_q;
  reg [1:0] stat_d;
  reg [1:0] mask_q;
  reg [1:0] mask_d;
  reg [5:0] rst_cnt_q;
  reg [5:0] rst_cnt_d;
  reg int_d;
  reg tmo_n_d;
  reg chip_rst_d;
  reg gear_d;
  reg pready_d;
  reg [31:0] prdata_d;
  reg pslverr_d;
  reg irq_d;
  reg [31:0] rd_d;
  reg hit_d;

  wire [2:0] per;
  wire enable;
  wire idle_run;
  wire rsel;
  wire acc;
  wire wr;
  wire wr_mode;
  wire wr_cmd;
  wire wr_nmi;
  wire wr_stat;
  wire wr_mask;
  wire clr_code;
  wire dis_code;
  wire stretch;
  wire armed;
  wire running;
  wire per_ok;
  wire [CNT_W-1:0] lim;
  wire ovf;
  wire ev_irq;
  wire ev_rst;

  // Address match for one register word
  function reg_sel;
    input [11:0] addr;
    input [11:0] off;
    begin
      reg_sel = (addr == off);
    end
  endfunction

  // Overflow exponent per period code; prohibited codes give none
  function [4:0] ovf_exp;
    input [2:0] code;
    begin
      case (code)
        3'h0: ovf_exp = `WDOC_EXP_P0;
        3'h1: ovf_exp = `WDOC_EXP_P1;
        3'h2: ovf_exp = `WDOC_EXP_P2;
        3'h3: ovf_exp = `WDOC_EXP_P3;
        3'h4: ovf_exp = `WDOC_EXP_P4;
        3'h5: ovf_exp = `WDOC_EXP_P5;
        default: ovf_exp = 5'h00;
      endcase
    end
  endfunction

  // Terminal count: low exponent bits all ones
  function [CNT_W-1:0] term_cnt;
    input [2:0] code;
    integer i;
    begin
      term_cnt = {CNT_W{1'b0}};
      for (i = 0; i < CNT_W; i = i + 1) begin
        if (i < ovf_exp(code))
          term_cnt[i] = 1'b1;
      end
    end
  endfunction

  assign per = mode_q[`WDOC_BIT_PER_HI:`WDOC_BIT_PER_LO];
  assign enable = mode_q[`WDOC_BIT_EN];
  assign idle_run = mode_q[`WDOC_BIT_IDLE];
  assign rsel = mode_q[`WDOC_BIT_RSEL];
  assign acc = PSEL & PENABLE & ~PREADY;
  assign wr = acc & PWRITE;
  assign wr_mode = wr & reg_sel(PADDR, `WDOC_OFF_MODE);
  assign wr_cmd = wr & reg_sel(PADDR, `WDOC_OFF_CMD);
  assign wr_nmi = wr & reg_sel(PADDR, `WDOC_OFF_NMIFLG);
  assign wr_stat = wr & reg_sel(PADDR, `WDOC_OFF_IRQ_STAT);
  assign wr_mask = wr & reg_sel(PADDR, `WDOC_OFF_IRQ_MASK);
  assign clr_code = wr_cmd & (PWDATA[7:0] == `WDOC_CODE_CLEAR);
  assign dis_code = wr_cmd & (PWDATA[7:0] == `WDOC_CODE_DISABLE) & ~enable;
  assign stretch = (state_q == ST_RST);
  assign armed = (state_q == ST_RUN);
  assign running = armed & ~DEBUG_HALT & (~IDLE_MODE | idle_run);
  assign per_ok = (per < 3'h6);
  assign lim = term_cnt(per);
  assign ovf = running & per_ok & ((cnt_q & lim) == lim);
  assign ev_irq = ovf & ~rsel;
  assign ev_rst = ovf & rsel;

  // Run, disabled, or stretching a watchdog reset
  always @* begin
    state_d = state_q;
    rst_cnt_d = rst_cnt_q;
    case (state_q)
      ST_RUN: begin
        if (ev_rst) begin
          state_d = ST_RST;
          rst_cnt_d = `WDOC_RST_STATES;
        end else if (dis_code) begin
          state_d = ST_OFF;
        end
      end
      ST_OFF: begin
        if (wr_mode & PWDATA[`WDOC_BIT_EN])
          state_d = ST_RUN;
      end
      ST_RST: begin
        rst_cnt_d = rst_cnt_q - 6'h01;
        if (rst_cnt_q == 6'h01)
          state_d = ST_RUN;
      end
      default: begin
        state_d = ST_RUN;
        rst_cnt_d = 6'h00;
      end
    endcase
  end

  // Watchdog reset reinitialises control state, not the stretch itself
  always @* begin
    mode_d = mode_q;
    nmi_flag_d = nmi_flag_q;
    mask_d = mask_q;
    if (stretch) begin
      mode_d = `WDOC_MODE_RST;
      nmi_flag_d = 1'b0;
      mask_d = 2'h0;
    end else begin
      if (wr_mode) begin
        mode_d[`WDOC_BIT_EN] = PWDATA[`WDOC_BIT_EN];
        mode_d[`WDOC_BIT_PER_HI:`WDOC_BIT_PER_LO] = PWDATA[`WDOC_BIT_PER_HI:`WDOC_BIT_PER_LO];
        mode_d[`WDOC_BIT_IDLE] = PWDATA[`WDOC_BIT_IDLE];
        mode_d[`WDOC_BIT_RSEL] = PWDATA[`WDOC_BIT_RSEL];
      end
      // Set wins over a clear-by-one in the same cycle
      if (ev_irq)
        nmi_flag_d = 1'b1;
      else if (wr_nmi & PWDATA[0])
        nmi_flag_d = 1'b0;
      if (wr_mask)
        mask_d = PWDATA[1:0];
    end
  end

  // Counter and overflow events
  always @* begin
    cnt_d = cnt_q;
    stat_d = stat_q;
    tmo_n_d = TIMEOUT_OUTPUT_N;
    int_d = 1'b0;
    if (stretch) begin
      cnt_d = {CNT_W{1'b0}};
      stat_d = 2'h0;
      tmo_n_d = 1'b1;
    end else begin
      if (clr_code | dis_code | ~armed | ovf)
        cnt_d = {CNT_W{1'b0}};
      else if (running)
        cnt_d = cnt_q + 1'b1;
      if (ev_irq)
        tmo_n_d = 1'b0;
      else if (clr_code)
        tmo_n_d = 1'b1;
      int_d = ev_irq;
      if (wr_stat)
        stat_d = stat_q & ~PWDATA[1:0];
      stat_d = stat_d | {ev_rst, ev_irq};
    end
  end

  // Reset pulse covers the event cycle plus all but the last stretch cycle
  always @* begin
    chip_rst_d = ev_rst | (rst_cnt_q > 6'h01);
    gear_d = ev_rst;
  end

  // Read mux
  always @* begin
    rd_d = 32'h0000_0000;
    hit_d = 1'b1;
    case (PADDR)
      `WDOC_OFF_MODE: rd_d = {24'h000000, mode_q};
      `WDOC_OFF_CMD: rd_d = 32'h0000_0000;
      `WDOC_OFF_NMIFLG: rd_d = {31'h0, nmi_flag_q};
      `WDOC_OFF_IRQ_STAT: rd_d = {30'h0, stat_q};
      `WDOC_OFF_IRQ_MASK: rd_d = {30'h0, mask_q};
      `WDOC_OFF_CNT: rd_d = {{(32-CNT_W){1'b0}}, cnt_q};
      default: hit_d = 1'b0;
    endcase
  end

  // One wait state: answer comes the cycle after the access phase opens
  always @* begin
    pready_d = acc;
    prdata_d = 32'h0000_0000;
    if (acc & ~PWRITE)
      prdata_d = rd_d;
    pslverr_d = acc & ~hit_d;
    irq_d = |(stat_q & mask_q);
  end

  // Stretch state survives its own reset so it can finish
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      state_q <= ST_RUN;
      rst_cnt_q <= 6'h00;
    end else begin
      state_q <= state_d;
      rst_cnt_q <= rst_cnt_d;
    end
  end

  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      mode_q <= `WDOC_MODE_RST;
    end else begin
      mode_q <= mode_d;
    end
  end

  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      nmi_flag_q <= 1'b0;
    end else begin
      nmi_flag_q <= nmi_flag_d;
    end
  end

  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      mask_q <= 2'h0;
    end else begin
      mask_q <= mask_d;
    end
  end

  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      cnt_q <= {CNT_W{1'b0}};
    end else begin
      cnt_q <= cnt_d;
    end
  end

  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      stat_q <= 2'h0;
    end else begin
      stat_q <= stat_d;
    end
  end

  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      TIMEOUT_OUTPUT_N <= 1'b1;
      WATCHDOG_INTERRUPT <= 1'b0;
    end else begin
      TIMEOUT_OUTPUT_N <= tmo_n_d;
      WATCHDOG_INTERRUPT <= int_d;
    end
  end

  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      CHIP_RESET <= 1'b0;
      CLOCK_GEAR_INIT <= 1'b0;
    end else begin
      CHIP_RESET <= chip_rst_d;
      CLOCK_GEAR_INIT <= gear_d;
    end
  end

  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= pready_d;
      PRDATA <= prdata_d;
      PSLVERR <= pslverr_d;
    end
  end

  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= irq_d;
    end
  end
endmodule

/* File: tb/wdoc_sva.sv */
// Watchdog event checker
`timescale 1ns/100ps
module wdoc_sva (
  input wire SYS_CLK,
  input wire SYS_RST,
  input wire WATCHDOG_INTERRUPT,
  input wire TIMEOUT_OUTPUT_N,
  input wire CHIP_RESET,
  input wire CLOCK_GEAR_INIT
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  tmo_low_a: assert property (WATCHDOG_INTERRUPT |-> !TIMEOUT_OUTPUT_N)
    else $error("timeout high");
  tmo_cause_a: assert property ($fell(TIMEOUT_OUTPUT_N) |-> WATCHDOG_INTERRUPT)
    else $error("timeout cause");
  int_pulse_a: assert property (WATCHDOG_INTERRUPT |=> !WATCHDOG_INTERRUPT)
    else $error("int long");
  one_event_a: assert property (!(WATCHDOG_INTERRUPT && CHIP_RESET))
    else $error("both events");
  rst_len_a: assert property ($rose(CHIP_RESET) |-> ##31 CHIP_RESET ##1 !CHIP_RESET)
    else $error("reset length");
  gear_a: assert property ($rose(CHIP_RESET) |-> CLOCK_GEAR_INIT)
    else $error("gear missing");
  gear_pulse_a: assert property (CLOCK_GEAR_INIT |-> CHIP_RESET ##1 !CLOCK_GEAR_INIT)
    else $error("gear pulse");
  rst_quiet_a: assert property ($fell(CHIP_RESET) |-> (!CHIP_RESET && !WATCHDOG_INTERRUPT)[*8])
    else $error("restart");
  cover property (WATCHDOG_INTERRUPT);
  cover property ($rose(CHIP_RESET));
  cover property ($rose(TIMEOUT_OUTPUT_N));
endmodule

/* File: tb/wdoc_top_tb.sv */
// Watchdog testbench
`timescale 1ns/100ps
module wdoc_top_tb;
  logic SYS_CLK = 0, SYS_RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, IDLE_MODE = 0;
  logic DEBUG_HALT = 0, PREADY, PSLVERR, WATCHDOG_INTERRUPT, TIMEOUT_OUTPUT_N, CHIP_RESET;
  logic CLOCK_GEAR_INIT, IRQ;
  logic [11:0] PADDR = 0;
  logic [31:0] PWDATA = 0, PRDATA, rd;
  int miscompares = 0, checks_done = 0, cyc = 0, n;
  integer seed = 32'h9007172A;
  wdoc_top dut (.SYS_CLK, .SYS_RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .PREADY, .PSLVERR, .IDLE_MODE, .DEBUG_HALT, .WATCHDOG_INTERRUPT, .TIMEOUT_OUTPUT_N,
    .CHIP_RESET, .CLOCK_GEAR_INIT, .IRQ);
  always #10 SYS_CLK = ~SYS_CLK;
  // Bit 31 always reads 0, so it carries the error flag
  task apb(input [11:0] a, input [31:0] d, input w);
    @(posedge SYS_CLK);
    PSEL <= 1;
    PADDR <= a;
    PWDATA <= d;
    PWRITE <= w;
    @(posedge SYS_CLK);
    PENABLE <= 1;
    do @(posedge SYS_CLK); while (PREADY !== 1);
    rd = {PSLVERR, PRDATA[30:0]};
    PSEL <= 0;
    PENABLE <= 0;
  endtask
  task chk(input string m, input [31:0] e, s);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", m, e, s);
    end
  endtask
  task wov;
    n = 0;
    while (WATCHDOG_INTERRUPT !== 1 && CHIP_RESET !== 1) begin
      @(posedge SYS_CLK);
      n++;
    end
  endtask
  task stop_test;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge SYS_CLK)
    if (++cyc == 70000) begin
      miscompares++;
      stop_test;
    end
  initial begin
    repeat (2) @(posedge SYS_CLK);
    SYS_RST <= 0;
    wov;
    chk("rst", 1, CHIP_RESET);
    chk("rper", 1, n > 32760 && n < 32772);
    repeat (40) @(posedge SYS_CLK);
    apb(0, 0, 0);
    chk("mode", 32'h82, rd);
    apb(12'h010, 1, 1);
    apb(0, 32'h80, 1);
    apb(4, 32'h4E, 1);
    wov;
    chk("int", 1, WATCHDOG_INTERRUPT);
    chk("iper", 1, n > 32760 && n < 32772);
    apb(8, 0, 0);
    chk("nmi", 1, rd);
    chk("irq", 1, IRQ);
    chk("tmo", 0, TIMEOUT_OUTPUT_N);
    apb(12'h00C, 3, 1);
    apb(4, 32'h4E, 1);
    chk("tmoh", 1, TIMEOUT_OUTPUT_N);
    apb(4, $random(seed) & 32'hFFFFFF0F, 1);
    apb(4, 32'hB1, 1);
    apb(20, 0, 0);
    chk("run", 1, rd != 0);
    DEBUG_HALT <= 1;
    apb(20, 0, 0);
    n = rd;
    apb(20, 0, 0);
    chk("halt", n, rd);
    DEBUG_HALT <= 0;
    apb(0, 0, 1);
    apb(4, 32'hB1, 1);
    apb(20, 0, 0);
    chk("dis", 0, rd);
    apb(0, 32'h80, 1);
    apb(20, 0, 0);
    chk("en", 1, rd != 0);
    IDLE_MODE <= 1;
    apb(20, 0, 0);
    n = rd;
    apb(20, 0, 0);
    chk("idle0", n, rd);
    apb(0, 32'h84, 1);
    apb(20, 0, 0);
    n = rd;
    apb(20, 0, 0);
    chk("idle1", 1, rd != n);
    IDLE_MODE <= 0;
    apb(12'h100, 0, 0);
    chk("err", 32'h80000000, rd);
    stop_test;
  end
endmodule
bind wdoc_top wdoc_sva u_sva (.SYS_CLK, .SYS_RST, .WATCHDOG_INTERRUPT, .TIMEOUT_OUTPUT_N,
  .CHIP_RESET, .CLOCK_GEAR_INIT);
